// ### km_channel_switch.sv
// Channel selection and routing policy for a secure keyboard/mouse switch.
// Assumes synchronous inputs on ref_clk; host side has no control inputs.
`timescale 1ns/1ns
`default_nettype none
module km_channel_switch
  import km_switch_pkg::*;
#(
  parameter int AUTH_OFF_CYCLES = AUTH_OFF_CYC  // Shorten in simulation
)
(
  input  wire logic                           ref_clk,       // 10 MHz clock
  input  wire logic                           rst,           // Async reset, high
  input  wire logic                           sel_req,       // Selection request pulse
  input  wire logic [HOST_W-1:0]              sel_host,      // Requested host
  input  wire logic [1:0]                     sel_src,       // Source of request
  input  wire logic [1:0]                     method_cfg,    // Active selection method
  input  wire logic                           admin_ok,      // Admin privilege established
  input  wire logic                           cfg_wr,        // Filter config write
  input  wire logic [2:0]                     cfg_kb_type,   // New type for keyboard port
  input  wire logic [2:0]                     cfg_pt_type,   // New type for pointer port
  input  wire logic [2:0]                     kb_dev_type,   // Type seen on keyboard port
  input  wire logic [2:0]                     pt_dev_type,   // Type seen on pointer port
  input  wire logic                           kb_valid,      // Keyboard byte valid
  input  wire logic [DATA_W-1:0]              kb_data,       // Keyboard byte
  input  wire logic                           pt_valid,      // Pointer byte valid
  input  wire logic [DATA_W-1:0]              pt_data,       // Pointer byte
  input  wire logic [NUM_HOSTS-1:0]           host_rx_valid, // Host-to-peripheral traffic
  output logic      [NUM_HOSTS-1:0]           host_kb_valid, // Keyboard byte per host
  output logic      [NUM_HOSTS*DATA_W-1:0]    host_kb_data,  // Keyboard data per host
  output logic      [NUM_HOSTS-1:0]           host_pt_valid, // Pointer byte per host
  output logic      [NUM_HOSTS*DATA_W-1:0]    host_pt_data,  // Pointer data per host
  output logic      [NUM_HOSTS-1:0]           host_led,      // Selected-host indicator
  output logic                                auth_pwr_en,   // Auth device supply on
  output logic                                kb_rejected,   // Keyboard port refused
  output logic                                pt_rejected,   // Pointer port refused
  output logic                                busy           // Switch in progress
);
  import km_switch_pkg::*;

  sw_state_e               state_q, state_d;
  logic [HOST_W-1:0]       host_q, host_d;
  logic [HOST_W-1:0]       pend_q, pend_d;
  logic [AUTH_CNT_W-1:0]   auth_cnt_q, auth_cnt_d;
  logic [PURGE_CNT_W-1:0]  purge_cnt_q, purge_cnt_d;
  logic [1:0]              method_q, method_d;
  logic [2:0]              kb_type_q, kb_type_d;
  logic [2:0]              pt_type_q, pt_type_d;
  logic                    kb_ok, pt_ok, sel_ok, purging;
  logic [NUM_HOSTS-1:0]    kb_wr, pt_wr;
  logic [NUM_HOSTS-1:0]    kb_out_v;
  logic [NUM_HOSTS*DATA_W-1:0] kb_out_d;
  logic [NUM_HOSTS-1:0]    pt_v_q, pt_v_d;
  logic [NUM_HOSTS*DATA_W-1:0] pt_d_q, pt_d_d;

  function automatic logic [NUM_HOSTS-1:0] onehot(input logic [HOST_W-1:0] h);
    onehot = '0;
    onehot[h] = 1'b1;
  endfunction

  localparam logic [AUTH_CNT_W-1:0] AUTH_LAST =
    AUTH_CNT_W'(AUTH_OFF_CYCLES - 1);
  localparam logic [PURGE_CNT_W-1:0] PURGE_LAST = PURGE_CNT_W'(PURGE_CYC - 1);

  // Method is latched only while idle; host_rx_valid never reaches here
  assign sel_ok  = sel_req && (sel_src == method_q)
                 && (sel_host != host_q) && (state_q == ST_RUN);
  assign kb_ok   = (kb_dev_type == kb_type_q);
  assign pt_ok   = (pt_dev_type == pt_type_q);
  assign purging = (state_q == ST_PURGE);

  always_comb
  begin
    state_d     = state_q;
    host_d      = host_q;
    pend_d      = pend_q;
    auth_cnt_d  = auth_cnt_q;
    purge_cnt_d = purge_cnt_q;
    method_d    = method_q;
    kb_type_d   = kb_type_q;
    pt_type_d   = pt_type_q;
    if (cfg_wr && admin_ok)
    begin
      kb_type_d = cfg_kb_type;
      pt_type_d = cfg_pt_type;
    end
    case (state_q)
      ST_RUN:
      begin
        // Only one method can be live; changes take effect between switches
        if ((method_cfg == SRC_BUTTON) || (method_cfg == SRC_HOTKEY))
          method_d = method_cfg;
        if (sel_ok)
        begin
          pend_d      = sel_host;
          state_d     = ST_PURGE;
          purge_cnt_d = '0;
        end
      end
      ST_PURGE:
      begin
        purge_cnt_d = purge_cnt_q + PURGE_CNT_W'(1);
        if (purge_cnt_q == PURGE_LAST)
        begin
          host_d     = pend_q;
          auth_cnt_d = '0;
          state_d    = ST_AUTH;
        end
      end
      ST_AUTH:
      begin
        auth_cnt_d = auth_cnt_q + AUTH_CNT_W'(1);
        if (auth_cnt_q == AUTH_LAST)
          state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q     <= ST_RUN;
      host_q      <= DEFAULT_HOST;
      pend_q      <= DEFAULT_HOST;
      auth_cnt_q  <= '0;
      purge_cnt_q <= '0;
      method_q    <= SRC_BUTTON;
      kb_type_q   <= TYPE_KEYBOARD;
      pt_type_q   <= TYPE_POINTER;
    end
    else
    begin
      state_q     <= state_d;
      host_q      <= host_d;
      pend_q      <= pend_d;
      auth_cnt_q  <= auth_cnt_d;
      purge_cnt_q <= purge_cnt_d;
      method_q    <= method_d;
      kb_type_q   <= kb_type_d;
      pt_type_q   <= pt_type_d;
    end
  end

  // One write strobe per host, only the selected one; no cross-host path
  assign kb_wr = (kb_valid && kb_ok && (state_q == ST_RUN))
               ? onehot(host_q) : '0;
  assign pt_wr = (pt_valid && pt_ok && (state_q == ST_RUN))
               ? onehot(host_q) : '0;

  genvar g;
  generate
    for (g = 0; g < NUM_HOSTS; g++)
    begin : g_host
      // Flop-only storage, lost at power-down
      km_kb_buffer u_kb_buf (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .purge    (purging),
        .wr_en    (kb_wr[g]),
        .wr_data  (kb_data),
        .rd_valid (kb_out_v[g]),
        .rd_data  (kb_out_d[g*DATA_W +: DATA_W])
      );
    end
  endgenerate

  always_comb
  begin
    pt_v_d = pt_wr;
    pt_d_d = '0;
    for (int i = 0; i < NUM_HOSTS; i++)
      if (pt_wr[i])
        pt_d_d[i*DATA_W +: DATA_W] = pt_data;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pt_v_q <= '0;
      pt_d_q <= '0;
    end
    else
    begin
      pt_v_q <= pt_v_d;
      pt_d_q <= pt_d_d;
    end
  end

  // host_rx_valid is deliberately left without any load
  assign host_kb_valid = kb_out_v;
  assign host_kb_data  = kb_out_d;
  assign host_pt_valid = pt_v_q;
  assign host_pt_data  = pt_d_q;
  assign host_led      = onehot(host_q);
  // Auth supply has its own control only; it carries no data
  assign auth_pwr_en   = (state_q != ST_AUTH);
  assign kb_rejected   = ~kb_ok;
  assign pt_rejected   = ~pt_ok;
  assign busy          = (state_q != ST_RUN);
endmodule
`default_nettype wire

// ### km_host_model.sv
// Host-side model: sends reverse traffic only; takes no routed bytes.
// Pattern changes every cycle so a leak or obeyed host shows.
`timescale 1ns/1ns
`default_nettype none
module km_host_model
(
  input  wire logic                                ref_clk,      // Clock
  input  wire logic                                rst,          // Reset
  output var  logic [km_switch_pkg::NUM_HOSTS-1:0] host_rx_valid // Reverse traffic
);
  import km_switch_pkg::*;
  logic [7:0] r_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      r_q <= 8'h5A;
    else
      r_q <= {r_q[6:0], r_q[7] ^ r_q[5]} + 8'h01;
  end
  assign host_rx_valid = r_q[NUM_HOSTS-1:0];
endmodule
`default_nettype wire

// ### km_kb_buffer.sv
// Small volatile keyboard buffer, one per host-facing interface.
// Contents held only in flip-flops; cleared on reset or purge.
`timescale 1ns/1ns
`default_nettype none
module km_kb_buffer
  import km_switch_pkg::*;
(
  input  wire logic              ref_clk,  // System clock
  input  wire logic              rst,      // Async reset
  input  wire logic              purge,    // Drop all contents
  input  wire logic              wr_en,    // Store a byte
  input  wire logic [DATA_W-1:0] wr_data,  // Byte in
  output logic                   rd_valid, // Byte waiting
  output logic      [DATA_W-1:0] rd_data   // Byte out, registered
);
  logic              valid_q, valid_d;
  logic [DATA_W-1:0] data_q, data_d;

  always_comb
  begin
    valid_d = valid_q;
    data_d  = data_q;
    if (purge)
    begin
      valid_d = 1'b0;
      data_d  = '0;
    end
    else if (wr_en)
    begin
      valid_d = 1'b1;
      data_d  = wr_data;
    end
    else
    begin
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      valid_q <= 1'b0;
      data_q  <= '0;
    end
    else
    begin
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

  assign rd_valid = valid_q;
  assign rd_data  = data_q;
endmodule
`default_nettype wire

// ### km_switch_assertions.sv
// Checker for km_channel_switch: routing, purge and auth power timing.
// Bound into the switch; watches its ports only.
`timescale 1ns/1ns
`default_nettype none
module km_switch_checker
#(
  parameter int AUTH_OFF_CYCLES = 20
)
(
  input wire logic                               ref_clk,       // Clock
  input wire logic                               rst,           // Reset
  input wire logic                               sel_req,       // Request
  input wire logic                               kb_valid,      // Key in
  input wire logic [km_switch_pkg::NUM_HOSTS-1:0] host_kb_valid, // Key out
  input wire logic [km_switch_pkg::NUM_HOSTS-1:0] host_pt_valid, // Pointer out
  input wire logic [km_switch_pkg::NUM_HOSTS-1:0] host_led,      // Indicator
  input wire logic                               auth_pwr_en,   // Auth power
  input wire logic                               kb_rejected,   // Key refused
  input wire logic                               busy           // Switching
);
  import km_switch_pkg::*;
  int off_q;
  // Repetition cannot reach a full second, so count low cycles
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      off_q <= 0;
    else
      off_q <= auth_pwr_en ? 0 : off_q + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_led; $onehot(host_led); endproperty
  a_led: assert property (p_led) else $error("indicator not one-hot");
  property p_kb; |host_kb_valid |-> host_kb_valid == host_led; endproperty
  a_kb: assert property (p_kb) else $error("key to wrong host");
  property p_pt; |host_pt_valid |-> host_pt_valid == host_led; endproperty
  a_pt: assert property (p_pt) else $error("pointer to wrong host");
  property p_src; $rose(busy) |-> $past(sel_req); endproperty
  a_src: assert property (p_src) else $error("switch without request");
  property p_hush; busy && $past(busy) |-> !(|{host_kb_valid, host_pt_valid}); endproperty
  a_hush: assert property (p_hush) else $error("data while switching");
  property p_purge;
    $rose(busy) |-> (auth_pwr_en && $stable(host_led))[*8] ##9 $changed(host_led);
  endproperty
  a_purge: assert property (p_purge) else $error("purge length wrong");
  property p_chg; $changed(host_led) |-> busy && !auth_pwr_en; endproperty
  a_chg: assert property (p_chg) else $error("host change outside switch");
  property p_amin; $rose(auth_pwr_en) |-> off_q >= AUTH_OFF_CYCLES; endproperty
  a_amin: assert property (p_amin) else $error("auth off too short");
  // Counter bound follows the off time; a fixed range breaks at one second
  property p_aback; !auth_pwr_en |-> off_q < AUTH_OFF_CYCLES; endproperty
  a_aback: assert property (p_aback) else $error("auth power not restored");
  property p_rej; kb_valid && kb_rejected |=> !(|host_kb_valid); endproperty
  a_rej: assert property (p_rej) else $error("refused key forwarded");
endmodule

bind km_channel_switch km_switch_checker #(.AUTH_OFF_CYCLES(AUTH_OFF_CYCLES)) chk_inst (
  .ref_clk, .rst, .sel_req, .kb_valid, .host_kb_valid, .host_pt_valid,
  .host_led, .auth_pwr_en, .kb_rejected, .busy);
`default_nettype wire

// ### km_switch_pkg.sv
// Package for the keyboard/mouse channel switch: sizes, timing, enums.
// Assumes a single 10 MHz system clock.
package km_switch_pkg;
  localparam int          NUM_HOSTS      = 4;
  localparam int          HOST_W         = 2;
  localparam int          DATA_W         = 8;
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          AUTH_OFF_MS    = 1000;
  // Least time; CLK_HZ/1000 divides exactly, so no rounding
  localparam int          AUTH_OFF_CYC   = (CLK_HZ / 1000) * AUTH_OFF_MS;
  localparam int          AUTH_CNT_W     = 24;
  localparam int          PURGE_CYC      = 16;
  localparam int          PURGE_CNT_W    = 5;
  localparam logic [HOST_W-1:0] DEFAULT_HOST = 2'h0;
  localparam logic [2:0]  TYPE_KEYBOARD  = 3'h1;
  localparam logic [2:0]  TYPE_POINTER   = 3'h2;
  localparam logic [2:0]  TYPE_AUTH      = 3'h3;
  localparam logic [1:0]  SRC_BUTTON     = 2'h0;
  localparam logic [1:0]  SRC_HOTKEY     = 2'h1;
  localparam int          HOLD_W         = 4;
  localparam logic [HOLD_W-1:0] HOLD_MAX = 4'hF;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_PURGE = 2'b01,
    ST_AUTH  = 2'b10
  } sw_state_e;
endpackage

// ### test_km_channel_switch.sv
// Testbench for km_channel_switch: routing, refusals, switching.
// Host model drives reverse traffic; bench drives the user side.
`timescale 1ns/1ns
`default_nettype none
module test_km_channel_switch;
  import km_switch_pkg::*;
  localparam int AOFF = 20;
  logic ref_clk = 1'b0, rst = 1'b1, sel_req = 1'b0, kb_valid = 1'b0, pt_valid = 1'b0;
  logic cfg_wr = 1'b0, admin_ok = 1'b0;
  logic [HOST_W-1:0] sel_host = 2'h0;
  logic [1:0] sel_src = 2'h0, method_cfg = 2'h0;
  logic [2:0] cfg_kb_type = 3'h1, cfg_pt_type = 3'h2, kb_dev_type = 3'h1, pt_dev_type = 3'h2;
  logic [DATA_W-1:0] kb_data = 8'h00, pt_data = 8'h00;
  wire logic [NUM_HOSTS-1:0] host_rx_valid, host_kb_valid, host_pt_valid, host_led;
  wire logic [NUM_HOSTS*DATA_W-1:0] host_kb_data, host_pt_data;
  wire logic auth_pwr_en, kb_rejected, pt_rejected, busy;
  logic [11:0] qk[$], qp[$];
  logic [31:0] s = 32'hb6f1b573;
  int n_fail = 0, checks = 0;
  always #50 ref_clk = ~ref_clk;
  km_channel_switch #(.AUTH_OFF_CYCLES(AOFF)) km_channel_switch_inst (
    .ref_clk, .rst, .sel_req, .sel_host, .sel_src, .method_cfg, .admin_ok, .cfg_wr,
    .cfg_kb_type, .cfg_pt_type, .kb_dev_type, .pt_dev_type, .kb_valid, .kb_data,
    .pt_valid, .pt_data, .host_rx_valid, .host_kb_valid, .host_kb_data, .host_pt_valid,
    .host_pt_data, .host_led, .auth_pwr_en, .kb_rejected, .pt_rejected, .busy);
  km_host_model km_host_model_inst (.ref_clk, .rst, .host_rx_valid);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] lane(input logic [3:0] v, input logic [31:0] d);
    lane = 8'h00;
    for (int i = 0; i < NUM_HOSTS; i++)
      if (v[i]) lane = d[DATA_W*i +: DATA_W];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Unexpected output meets an empty queue and fails
  always @(posedge ref_clk)
  begin
    if (!rst && (|host_kb_valid) === 1'b1)
      chk({host_kb_valid, lane(host_kb_valid, host_kb_data)}, qk.size() ? qk.pop_front() : 0);
    if (!rst && (|host_pt_valid) === 1'b1)
      chk({host_pt_valid, lane(host_pt_valid, host_pt_data)}, qp.size() ? qp.pop_front() : 0);
  end
  task automatic send(input logic k, p, input logic [1:0] h, input logic e, input int n);
    repeat (n)
    begin
      s = lfsr(s);
      @(posedge ref_clk);
      kb_valid <= k;
      pt_valid <= p;
      kb_data <= s[7:0];
      pt_data <= s[15:8];
      if (e && k) qk.push_back({4'h1 << h, s[7:0]});
      if (e && p) qp.push_back({4'h1 << h, s[15:8]});
    end
    @(posedge ref_clk);
    kb_valid <= 1'b0;
    pt_valid <= 1'b0;
  endtask
  task automatic sw(input logic [1:0] src, input logic [1:0] h, input logic ok);
    logic [3:0] led;
    int n;
    led = host_led;
    n = 0;
    @(posedge ref_clk);
    sel_req <= 1'b1;
    sel_src <= src;
    sel_host <= h;
    @(posedge ref_clk);
    sel_req <= 1'b0;
    @(posedge ref_clk);
    #1 chk(busy, ok);
    if (ok) send(1'b1, 1'b1, h, 1'b0, 2); // Dropped while busy
    while (busy === 1'b1 && n < 300)
    begin
      @(posedge ref_clk);
      #1 n = n + (auth_pwr_en ? 0 : 1);
    end
    chk({busy, auth_pwr_en}, 2'h1);
    chk(n >= AOFF, ok);
    chk(host_led, ok ? 4'h1 << h : led);
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk({host_led, auth_pwr_en, busy}, 6'h06);
    send(1'b1, 1'b1, 2'h0, 1'b1, 4);
    kb_dev_type <= 3'h3;
    pt_dev_type <= 3'h3;
    cfg_kb_type <= 3'h3;
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    #1 chk({kb_rejected, pt_rejected}, 2'h3);
    send(1'b1, 1'b1, 2'h0, 1'b0, 2);
    @(posedge ref_clk);
    admin_ok <= 1'b1;
    cfg_wr <= 1'b1;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    admin_ok <= 1'b0;
    pt_dev_type <= 3'h2;
    #1 chk({kb_rejected, pt_rejected}, 2'h0);
    send(1'b1, 1'b0, 2'h0, 1'b1, 1);
    sw(2'h1, 2'h2, 1'b0);
    sw(2'h0, 2'h0, 1'b0);
    sw(2'h0, 2'h2, 1'b1);
    send(1'b1, 1'b1, 2'h2, 1'b1, 3);
    method_cfg <= 2'h1;
    sw(2'h0, 2'h3, 1'b0);
    @(posedge ref_clk);
    method_cfg <= 2'h3; // Unknown code must leave hotkey live
    sw(2'h1, 2'h3, 1'b1);
    send(1'b1, 1'b1, 2'h3, 1'b1, 2);
    repeat (4) @(posedge ref_clk);
    chk(qk.size() + qp.size(), 0);
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
